// ---- logic/tlb_debug_defines.svh ----
// Purpose: Offsets, field positions and reset values of the cache read-out registers
// Assumes: Byte offsets inside global_space_zero, 12-bit decoded page
// Notes: Definitions only
`ifndef TLB_DEBUG_DEFINES_SVH
`define TLB_DEBUG_DEFINES_SVH

`define TDR_ADDR_W 12
`define TDR_AGENT_PTR_OFS 12'h080
`define TDR_AGENT_DATA_OFS 12'h084
`define TDR_WALKER_PTR_OFS 12'h088
`define TDR_WALKER_DATA_OFS 12'h08c

`define TDR_PTR_RESET 32'h0000_0000
`define TDR_DATA_RESET 32'h0000_0000
`define TDR_PTR_WMASK 32'hffff_fffc

`define TDR_UNIT_MSB 31
`define TDR_UNIT_LSB 24
`define TDR_ENTRY_MSB 15
`define TDR_ENTRY_LSB 4
`define TDR_STEP_MSB 15
`define TDR_STEP_LSB 2

`define TDR_SECURE_BIT 1

`endif

// ---- logic/tlb_debug_pkg.sv ----
// Purpose: Types shared by the cache read-out logic
// Assumes: Field widths match the pointer layout
// Notes: Constants live in the defines header
`default_nettype none

package tlb_debug_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2,
    RESP_DECERR = 2'h3
  } axi_resp_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_AGENT_PTR,
    SEL_AGENT_DATA,
    SEL_WALKER_PTR,
    SEL_WALKER_DATA
  } reg_sel_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_ACK = 2'b01,
    WR_RESP = 2'b11
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_TAKE = 2'b01,
    RD_FETCH = 2'b11,
    RD_RESP = 2'b10
  } rd_state_t;

  typedef struct packed {
    logic [7:0] unitSel;
    logic [7:0] reserved;
    logic [11:0] entryIdx;
    logic [3:0] wordIdx;
  } agent_ptr_t;

  typedef struct packed {
    logic [3:0] reserved;
    logic [1:0] sourceSel;
    logic [1:0] waySel;
    logic [7:0] reservedLow;
    logic [11:0] entryIdx;
    logic [3:0] wordIdx;
  } walker_ptr_t;

  typedef struct packed {
    logic walker;
    logic [7:0] unitSel;
    logic [1:0] sourceSel;
    logic [1:0] waySel;
    logic [11:0] entryIdx;
    logic [1:0] wordIdx;
  } fetch_req_t;

endpackage : tlb_debug_pkg

`default_nettype wire

// ---- logic/debug_read_pointer.sv ----
// Purpose: One read pointer register with byte writes, word advance and bounds check
// Assumes: Write and advance never come in the same cycle; write wins if they do
// Notes: Advance steps bits 15:2 only and wraps there
`default_nettype none
`include "tlb_debug_defines.svh"

module debug_read_pointer #(
  parameter int ENTRIES = 128,
  parameter int UNITS = 4,
  parameter bit CHECK_UNIT = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Software write
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  input wire logic [3:0] wrStrb,
  // Step after a data read
  input wire logic advance,
  // State
  output logic [31:0] ptr_r,
  output logic inBounds
);
  import tlb_debug_pkg::*;

  logic [31:0] merged;
  logic [31:0] ptr_nxt;
  logic [13:0] stepped;
  logic entryOk;
  logic unitOk;

  for (genvar g = 0; g < 4; g++)
  begin : g_lane
    assign merged[8*g +: 8] = wrStrb[g] ? wrData[8*g +: 8] : ptr_r[8*g +: 8];
  end

  assign stepped = ptr_r[`TDR_STEP_MSB:`TDR_STEP_LSB] + 14'h1;
  assign ptr_nxt = wrEn ? (merged & `TDR_PTR_WMASK) :
    advance ? {ptr_r[31:16], stepped, 2'b00} : ptr_r;
  assign entryOk = {1'b0, ptr_r[`TDR_ENTRY_MSB:`TDR_ENTRY_LSB]} < 13'(ENTRIES);
  assign unitOk = !CHECK_UNIT ||
    ({1'b0, ptr_r[`TDR_UNIT_MSB:`TDR_UNIT_LSB]} < 9'(UNITS));
  assign inBounds = entryOk && unitOk;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ptr_r <= `TDR_PTR_RESET;
    else
      ptr_r <= ptr_nxt;
  end

  property p_low_zero;
    @(posedge clock) disable iff (!rst_n) ptr_r[1:0] == 2'b00;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("pointer low bits not zero");

  property p_advance;
    @(posedge clock) disable iff (!rst_n)
      (advance && !wrEn) |=> (ptr_r[15:2] == $past(ptr_r[15:2]) + 14'h1) &&
        (ptr_r[31:16] == $past(ptr_r[31:16]));
  endproperty
  a_advance: assert property (p_advance)
    else $error("pointer did not advance by one word");

  property p_unit_bounds;
    @(posedge clock) disable iff (!rst_n)
      (CHECK_UNIT && ({1'b0, ptr_r[31:24]} >= 9'(UNITS))) |-> !inBounds;
  endproperty
  a_unit_bounds: assert property (p_unit_bounds)
    else $error("unit select beyond range reported in bounds");

endmodule : debug_read_pointer

`default_nettype wire

// ---- logic/tlb_word_fetch.sv ----
// Purpose: Request and ack port toward the cache storage for one word
// Assumes: Storage answers on the same clock; ack may come any cycle after the request
// Notes: Request holds until ack; done is a pulse the cycle after ack
`default_nettype none

module tlb_word_fetch (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // From the read sequencer
  input wire logic start,
  input wire tlb_debug_pkg::fetch_req_t info,
  output logic done_r,
  output logic [31:0] data_r,
  // Toward the cache storage
  output logic fetchReq_r,
  output tlb_debug_pkg::fetch_req_t fetchInfo_r,
  input wire logic fetchAck,
  input wire logic [31:0] fetchData
);
  import tlb_debug_pkg::*;

  logic taken;

  assign taken = fetchReq_r && fetchAck;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetchReq_r <= 1'b0;
      fetchInfo_r <= '0;
      done_r <= 1'b0;
      data_r <= 32'h0000_0000;
    end
    else
    begin
      fetchReq_r <= start || (fetchReq_r && !fetchAck);
      done_r <= taken;
      if (start)
        fetchInfo_r <= info;
      if (taken)
        data_r <= fetchData;
    end
  end

  property p_req_hold;
    @(posedge clock) disable iff (!rst_n)
      (fetchReq_r && !fetchAck) |=> fetchReq_r && $stable(fetchInfo_r);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("fetch request dropped before ack");

endmodule : tlb_word_fetch

`default_nettype wire

// ---- logic/tlb_debug_readout.sv ----
// Purpose: Secure read-out of translation cache words over the AXI4 programming port
// Assumes: Single-beat AXI4 accesses; cache storage sits behind the fetch port
// Notes: Write takes priority over a read arriving in the same idle cycle
`default_nettype none
`include "tlb_debug_defines.svh"

module tlb_debug_readout #(
  parameter int ID_W = 4,
  parameter int AGENT_UNITS = 4,
  parameter int AGENT_ENTRIES = 128,
  parameter int WALKER_ENTRIES = 512
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AXI4 write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [`TDR_ADDR_W-1:0] awaddr,
  input wire logic [ID_W-1:0] awid,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4 write response
  output logic bvalid,
  input wire logic bready,
  output tlb_debug_pkg::axi_resp_t bresp,
  output logic [ID_W-1:0] bid,
  // AXI4 read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [`TDR_ADDR_W-1:0] araddr,
  input wire logic [ID_W-1:0] arid,
  input wire logic [2:0] arprot,
  // AXI4 read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output tlb_debug_pkg::axi_resp_t rresp,
  output logic [ID_W-1:0] rid,
  output logic rlast,
  // Cache storage port
  output logic fetchReq_r,
  output tlb_debug_pkg::fetch_req_t fetchInfo_r,
  input wire logic fetchAck,
  input wire logic [31:0] fetchData
);
  import tlb_debug_pkg::*;

  function automatic reg_sel_t decodeAddr(input logic [`TDR_ADDR_W-1:0] addr);
    logic [`TDR_ADDR_W-1:0] word;
    word = {addr[`TDR_ADDR_W-1:2], 2'b00};
    case (word)
      `TDR_AGENT_PTR_OFS: decodeAddr = SEL_AGENT_PTR;
      `TDR_AGENT_DATA_OFS: decodeAddr = SEL_AGENT_DATA;
      `TDR_WALKER_PTR_OFS: decodeAddr = SEL_WALKER_PTR;
      `TDR_WALKER_DATA_OFS: decodeAddr = SEL_WALKER_DATA;
      default: decodeAddr = SEL_NONE;
    endcase
  endfunction : decodeAddr

  wr_state_t wrState_r;
  wr_state_t wrState_nxt;
  rd_state_t rdState_r;
  rd_state_t rdState_nxt;
  logic [31:0] agentPtr;
  logic [31:0] walkerPtr;
  logic agentOk;
  logic walkerOk;
  agent_ptr_t agentView;
  walker_ptr_t walkerView;
  logic rdWalker_r;
  logic fetchDone;
  logic [31:0] fetchWord;

  // Write side
  reg_sel_t wrSel;
  logic wrSecure;
  logic wrStart;
  logic wrTake;
  logic agentPtrWr;
  logic walkerPtrWr;

  assign wrSel = decodeAddr(awaddr);
  assign wrSecure = !awprot[`TDR_SECURE_BIT];
  assign wrStart = (wrState_r == WR_IDLE) && (rdState_r == RD_IDLE) && awvalid && wvalid;
  assign wrTake = (wrState_r == WR_ACK);
  // Data offsets decode but never enable a store
  assign agentPtrWr = wrTake && wrSecure && (wrSel == SEL_AGENT_PTR);
  assign walkerPtrWr = wrTake && wrSecure && (wrSel == SEL_WALKER_PTR);

  always_comb
  begin
    case (wrState_r)
      WR_IDLE: wrState_nxt = wrStart ? WR_ACK : WR_IDLE;
      WR_ACK: wrState_nxt = WR_RESP;
      WR_RESP: wrState_nxt = bready ? WR_IDLE : WR_RESP;
      default: wrState_nxt = WR_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrState_r <= WR_IDLE;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      bid <= '0;
    end
    else
    begin
      wrState_r <= wrState_nxt;
      awready <= (wrState_nxt == WR_ACK);
      wready <= (wrState_nxt == WR_ACK);
      bvalid <= (wrState_nxt == WR_RESP);
      if (wrTake)
      begin
        bresp <= (wrSel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        bid <= awid;
      end
    end
  end

  // Read side
  reg_sel_t rdSel;
  logic rdSecure;
  logic rdStart;
  logic rdTake;
  logic rdIsData;
  logic rdIsWalker;
  logic rdBound;
  logic needFetch;
  logic [31:0] takeData;
  axi_resp_t takeResp;
  fetch_req_t fetchSel;

  assign rdSel = decodeAddr(araddr);
  assign rdSecure = !arprot[`TDR_SECURE_BIT];
  assign rdStart = (rdState_r == RD_IDLE) && (wrState_r == WR_IDLE) &&
    !(awvalid && wvalid) && arvalid;
  assign rdTake = (rdState_r == RD_TAKE);
  assign rdIsData = (rdSel == SEL_AGENT_DATA) || (rdSel == SEL_WALKER_DATA);
  assign rdIsWalker = (rdSel == SEL_WALKER_DATA) || (rdSel == SEL_WALKER_PTR);
  assign rdBound = rdIsWalker ? walkerOk : agentOk;
  assign needFetch = rdSecure && rdIsData && rdBound;

  // Non-secure reads of mapped offsets see zero, so no cache content leaks
  assign takeData = !rdSecure ? 32'h0000_0000 :
    (rdSel == SEL_AGENT_PTR) ? agentPtr :
    (rdSel == SEL_WALKER_PTR) ? walkerPtr : 32'h0000_0000;
  assign takeResp = (rdSel == SEL_NONE) ? RESP_DECERR :
    (rdSecure && rdIsData && !rdBound) ? RESP_SLVERR : RESP_OKAY;

  assign agentView = agent_ptr_t'(agentPtr);
  assign walkerView = walker_ptr_t'(walkerPtr);
  assign fetchSel = rdIsWalker ?
    fetch_req_t'{walker: 1'b1, unitSel: 8'h00, sourceSel: walkerView.sourceSel,
      waySel: walkerView.waySel, entryIdx: walkerView.entryIdx,
      wordIdx: walkerView.wordIdx[3:2]} :
    fetch_req_t'{walker: 1'b0, unitSel: agentView.unitSel, sourceSel: 2'b00,
      waySel: 2'b00, entryIdx: agentView.entryIdx,
      wordIdx: agentView.wordIdx[3:2]};

  always_comb
  begin
    case (rdState_r)
      RD_IDLE: rdState_nxt = rdStart ? RD_TAKE : RD_IDLE;
      RD_TAKE: rdState_nxt = needFetch ? RD_FETCH : RD_RESP;
      RD_FETCH: rdState_nxt = fetchDone ? RD_RESP : RD_FETCH;
      RD_RESP: rdState_nxt = rready ? RD_IDLE : RD_RESP;
      default: rdState_nxt = RD_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdState_r <= RD_IDLE;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rlast <= 1'b0;
      rdata <= `TDR_DATA_RESET;
      rresp <= RESP_OKAY;
      rid <= '0;
      rdWalker_r <= 1'b0;
    end
    else
    begin
      rdState_r <= rdState_nxt;
      arready <= (rdState_nxt == RD_TAKE);
      rvalid <= (rdState_nxt == RD_RESP);
      rlast <= (rdState_nxt == RD_RESP);
      if (rdTake)
      begin
        rdata <= takeData;
        rresp <= takeResp;
        rid <= arid;
        rdWalker_r <= rdIsWalker;
      end
      else if (fetchDone)
      begin
        rdata <= fetchWord;
        rresp <= RESP_OKAY;
      end
    end
  end

  // Pointers step only after the word has come back, so the reply is the old location
  debug_read_pointer #(
    .ENTRIES(AGENT_ENTRIES),
    .UNITS(AGENT_UNITS),
    .CHECK_UNIT(1'b1)
  ) u_agent_ptr (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(agentPtrWr),
    .wrData(wdata),
    .wrStrb(wstrb),
    .advance(fetchDone && !rdWalker_r),
    .ptr_r(agentPtr),
    .inBounds(agentOk)
  );

  debug_read_pointer #(
    .ENTRIES(WALKER_ENTRIES),
    .UNITS(1),
    .CHECK_UNIT(1'b0)
  ) u_walker_ptr (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(walkerPtrWr),
    .wrData(wdata),
    .wrStrb(wstrb),
    .advance(fetchDone && rdWalker_r),
    .ptr_r(walkerPtr),
    .inBounds(walkerOk)
  );

  tlb_word_fetch u_fetch (
    .clock(clock),
    .rst_n(rst_n),
    .start(rdTake && needFetch),
    .info(fetchSel),
    .done_r(fetchDone),
    .data_r(fetchWord),
    .fetchReq_r(fetchReq_r),
    .fetchInfo_r(fetchInfo_r),
    .fetchAck(fetchAck),
    .fetchData(fetchData)
  );

  property p_data_write_ignored;
    @(posedge clock) disable iff (!rst_n)
      (wrTake && ((wrSel == SEL_AGENT_DATA) || (wrSel == SEL_WALKER_DATA)))
        |=> $stable(agentPtr) && $stable(walkerPtr);
  endproperty
  a_data_write_ignored: assert property (p_data_write_ignored)
    else $error("data register write changed a pointer");

  property p_nonsecure_write;
    @(posedge clock) disable iff (!rst_n)
      (wrTake && !wrSecure) |=> $stable(agentPtr) && $stable(walkerPtr);
  endproperty
  a_nonsecure_write: assert property (p_nonsecure_write)
    else $error("non-secure write reached a pointer");

  property p_agent_ptr_write;
    @(posedge clock) disable iff (!rst_n)
      (wrTake && wrSecure && (wrSel == SEL_AGENT_PTR) && (wstrb == 4'hf))
        |=> agentPtr == ($past(wdata) & 32'hffff_fffc);
  endproperty
  a_agent_ptr_write: assert property (p_agent_ptr_write)
    else $error("agent pointer write at 0x80 not stored");

  property p_walker_ptr_write;
    @(posedge clock) disable iff (!rst_n)
      (wrTake && wrSecure && (awaddr[11:2] == 10'h022) && (wstrb == 4'hf))
        |=> walkerPtr == ($past(wdata) & 32'hffff_fffc);
  endproperty
  a_walker_ptr_write: assert property (p_walker_ptr_write)
    else $error("walker pointer write at 0x88 not stored");

  property p_slverr;
    @(posedge clock) disable iff (!rst_n)
      (rdTake && rdSecure && rdIsData && !rdBound)
        |=> rvalid && (rresp == RESP_SLVERR) && !fetchReq_r;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("out of bounds read did not answer SLVERR");

  property p_fetch_data;
    @(posedge clock) disable iff (!rst_n)
      fetchDone |=> rvalid && (rresp == RESP_OKAY) && (rdata == $past(fetchWord));
  endproperty
  a_fetch_data: assert property (p_fetch_data)
    else $error("fetched word not returned");

endmodule : tlb_debug_readout

`default_nettype wire

// ---- sim/cache_store_model.sv ----
// Purpose: Cache storage stand-in that answers word fetches
// Assumes: Ack comes ackDelay cycles after the request is raised
// Notes: Data away from an ack is the inverse of the last word, so it is never stale
`default_nettype none

module cache_store_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fetch port
  input wire logic fetchReq_r,
  input wire tlb_debug_pkg::fetch_req_t fetchInfo_r,
  output logic fetchAck,
  output logic [31:0] fetchData,
  // Pace
  input wire logic [3:0] ackDelay
);
  timeunit 1ns;
  timeprecision 1ps;
  import tlb_debug_pkg::*;
  logic [3:0] waitCnt_r;
  logic [31:0] last_r;
  logic [31:0] word;
  logic wk;
  // Fields that one kind of pointer does not own are masked out
  assign wk = fetchInfo_r.walker;
  assign word = {5'h0a, wk, wk ? 8'h00 : fetchInfo_r.unitSel,
    wk ? fetchInfo_r.sourceSel : 2'h0, wk ? fetchInfo_r.waySel : 2'h0,
    fetchInfo_r.entryIdx, fetchInfo_r.wordIdx};
  assign fetchAck = fetchReq_r && (waitCnt_r >= ackDelay);
  assign fetchData = fetchAck ? word : ~last_r;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitCnt_r <= 4'h0;
      last_r <= 32'h0;
    end
    else
    begin
      waitCnt_r <= (fetchReq_r && !fetchAck) ? waitCnt_r + 4'h1 : 4'h0;
      if (fetchAck)
        last_r <= word;
    end
  end
endmodule : cache_store_model

`default_nettype wire

// ---- sim/test_tlb_debug_readout.sv ----
// Purpose: Self-checking bench for the cache read-out registers
// Assumes: Small entry counts so that the bounds are reachable
// Notes: Inputs move on the falling edge only
`default_nettype none
`include "tlb_debug_defines.svh"
`define CHK(g, e) check(32'(g), 32'(e))

module test_tlb_debug_readout;
  timeunit 1ns;
  timeprecision 1ps;
  import tlb_debug_pkg::*;
  localparam int AU = 4;
  localparam int AE = 8;
  localparam int WE = 16;
  localparam int NR = 33;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [2:0] prot;
    logic [31:0] wdata;
    logic [3:0] strb;
    logic [1:0] resp;
  } row_t;
  localparam row_t rows [NR] = '{
    '{1'b0, 12'h080, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b0, 12'h088, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b1, 12'h080, 3'h0, 32'h0300_0037, 4'hf, 2'h0},
    '{1'b0, 12'h080, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b0, 12'h084, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b0, 12'h084, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b0, 12'h084, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b0, 12'h080, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b1, 12'h084, 3'h0, 32'hffff_ffff, 4'hf, 2'h0},
    '{1'b0, 12'h080, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b1, 12'h080, 3'h0, 32'hffab_ff08, 4'h1, 2'h0},
    '{1'b1, 12'h080, 3'h0, 32'h00ab_0000, 4'h4, 2'h0},
    '{1'b0, 12'h080, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b0, 12'h084, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b1, 12'h088, 3'h0, 32'h0300_0000, 4'hf, 2'h0},
    '{1'b0, 12'h08c, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b1, 12'h088, 3'h0, 32'h0400_0010, 4'hf, 2'h0},
    '{1'b0, 12'h08c, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b1, 12'h088, 3'h0, 32'h0a00_0020, 4'hf, 2'h0},
    '{1'b0, 12'h08c, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b1, 12'h088, 3'h0, 32'h0d00_00f0, 4'hf, 2'h0},
    '{1'b0, 12'h08c, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b1, 12'h088, 3'h0, 32'h0000_0100, 4'hf, 2'h0},
    '{1'b0, 12'h08c, 3'h0, 32'h0, 4'h0, 2'h2},
    '{1'b1, 12'h080, 3'h2, 32'h0, 4'hf, 2'h0},
    '{1'b0, 12'h080, 3'h2, 32'h0, 4'h0, 2'h0},
    '{1'b0, 12'h090, 3'h0, 32'h0, 4'h0, 2'h3},
    '{1'b1, 12'h000, 3'h0, 32'h1, 4'hf, 2'h3},
    '{1'b1, 12'h080, 3'h0, 32'h0400_0000, 4'hf, 2'h0},
    '{1'b0, 12'h084, 3'h0, 32'h0, 4'h0, 2'h2},
    '{1'b1, 12'h080, 3'h0, 32'h0000_007c, 4'hf, 2'h0},
    '{1'b0, 12'h084, 3'h0, 32'h0, 4'h0, 2'h0},
    '{1'b0, 12'h084, 3'h0, 32'h0, 4'h0, 2'h2}};
  logic clock, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rlast, fetchReq_r, fetchAck;
  logic [11:0] awaddr, araddr;
  logic [3:0] awid, arid, bid, rid, wstrb, ackDelay;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, fetchData, aPtr, wPtr;
  axi_resp_t bresp, rresp;
  fetch_req_t fetchInfo_r;
  int bad_count = 0;
  int total_checks = 0;

  tlb_debug_readout #(.ID_W(4), .AGENT_UNITS(AU), .AGENT_ENTRIES(AE), .WALKER_ENTRIES(WE))
  uut (.clock, .rst_n, .awvalid, .awready, .awaddr, .awid, .awprot, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .bid, .arvalid, .arready, .araddr, .arid,
    .arprot, .rvalid, .rready, .rdata, .rresp, .rid, .rlast, .fetchReq_r, .fetchInfo_r,
    .fetchAck, .fetchData);

  cache_store_model store (.clock, .rst_n, .fetchReq_r, .fetchInfo_r, .fetchAck, .fetchData,
    .ackDelay);

  always #10 clock = ~clock;

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  task automatic results;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  function automatic logic inb(input logic wk, input logic [31:0] p);
    return wk ? (p[15:4] < WE) : (p[31:24] < AU && p[15:4] < AE);
  endfunction : inb

  function automatic logic [31:0] expWord(input logic wk, input logic [31:0] p);
    return {5'h0a, wk, wk ? 8'h00 : p[31:24], wk ? p[27:26] : 2'h0,
      wk ? p[25:24] : 2'h0, p[15:4], p[3:2]};
  endfunction : expWord

  // One access; the bench keeps its own copy of both pointers
  task automatic doRow(input row_t r, input int stall);
    logic wk, dat, map, sec;
    logic [31:0] p, e, d, m;
    logic [1:0] rs;
    int n;
    wk = r.addr[3];
    dat = r.addr[2];
    map = r.addr[11:4] == 8'h08 && r.addr[1:0] == 2'h0;
    sec = !r.prot[1];
    p = wk ? wPtr : aPtr;
    e = 32'h0;
    n = 0;
    @(negedge clock);
    if (r.wr)
    begin
      awvalid = 1; wvalid = 1; awaddr = r.addr; wdata = r.wdata; wstrb = r.strb;
      awprot = r.prot; awid = awid + 4'h1; bready = 1;
      while (!(awready === 1'b1 && wready === 1'b1) && n < 50)
      begin
        @(negedge clock);
        n++;
      end
      @(negedge clock);
      awvalid = 0; wvalid = 0;
      while (bvalid !== 1'b1 && n < 50)
      begin
        @(negedge clock);
        n++;
      end
      rs = bresp;
      `CHK(bid, awid);
      m = {{8{r.strb[3]}}, {8{r.strb[2]}}, {8{r.strb[1]}}, {8{r.strb[0]}}} & `TDR_PTR_WMASK;
      if (map && sec && !dat)
        p = (p & ~m) | (r.wdata & m);
    end
    else
    begin
      arvalid = 1; araddr = r.addr; arprot = r.prot; arid = arid + 4'h1; rready = 0;
      while (arready !== 1'b1 && n < 50)
      begin
        @(negedge clock);
        n++;
      end
      @(negedge clock);
      arvalid = 0;
      while (rvalid !== 1'b1 && n < 50)
      begin
        @(negedge clock);
        n++;
      end
      // Held answer must survive a stalled master
      repeat (stall)
      begin
        @(negedge clock);
        `CHK(rvalid, 1'b1);
      end
      rready = 1; d = rdata; rs = rresp;
      `CHK({rlast, rid}, {1'b1, arid});
      if (map && sec)
        e = !dat ? p : inb(wk, p) ? expWord(wk, p) : 32'h0;
      if (map && sec && dat && inb(wk, p))
        p[15:2] = p[15:2] + 14'h1;
      `CHK(d, e);
    end
    @(negedge clock);
    bready = 0; rready = 0;
    `CHK(rs, r.resp);
    if (wk)
      wPtr = p;
    else
      aPtr = p;
    if (n >= 50)
    begin
      bad_count++;
      results();
    end
  endtask : doRow

  initial
  begin
    clock = 0; rst_n = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; awid = 0; arid = 0; awprot = 0; arprot = 0; wdata = 0;
    wstrb = 0; ackDelay = 0; aPtr = 0; wPtr = 0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst_n = 1;
    for (int i = 0; i < NR; i++)
    begin
      doRow(rows[i], 0);
      $display("row %0d done", i);
    end
    // Slow storage, stalled master, back-to-back data reads
    ackDelay = 4'h5;
    doRow(row_t'{1'b1, 12'h080, 3'h0, 32'h0100_0010, 4'hf, 2'h0}, 0);
    doRow(row_t'{1'b0, 12'h084, 3'h0, 32'h0, 4'h0, 2'h0}, 3);
    doRow(row_t'{1'b0, 12'h084, 3'h0, 32'h0, 4'h0, 2'h0}, 0);
    $display("slow storage done");
    // Reset in mid-run clears both pointers
    ackDelay = 4'h0;
    doRow(row_t'{1'b1, 12'h088, 3'h0, 32'h0500_0040, 4'hf, 2'h0}, 0);
    rst_n = 0; aPtr = 0; wPtr = 0;
    repeat (2) @(negedge clock);
    rst_n = 1;
    doRow(row_t'{1'b0, 12'h088, 3'h0, 32'h0, 4'h0, 2'h0}, 0);
    doRow(row_t'{1'b0, 12'h080, 3'h0, 32'h0, 4'h0, 2'h0}, 0);
    doRow(row_t'{1'b0, 12'h08c, 3'h0, 32'h0, 4'h0, 2'h0}, 0);
    $display("reset test done");
    results();
  end
endmodule : test_tlb_debug_readout

`default_nettype wire
